/* File: inc/lut_ram_defs.svh */
// Constants of the logic-block distributed memory: offsets, fields, resets, timing
`ifndef LUT_RAM_DEFS_SVH
`define LUT_RAM_DEFS_SVH
`define ADDR_W 8
`define OFF_CTRL 8'h00
`define OFF_HFUNC 8'h04
`define OFF_INIT_A 8'h08
`define OFF_INIT_B 8'h0C
`define OFF_STATUS 8'h10
`define CTRL_W 11
`define CTRL_RESET 11'h000
`define HFUNC_RESET 8'h00
`define MEM_INIT 16'h0000
`define STS_STALL_BIT 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define CLK_PERIOD_NS 10
`define STALL_TIME_NS 1000000
`define STALL_CYCLES (`STALL_TIME_NS / `CLK_PERIOD_NS)
`define CNT_W 17
`endif

/* File: inc/lut_ram_pkg.sv */
// Types of the logic-block distributed memory
package lut_ram_pkg;
    typedef enum logic [1:0] {
        MODE_16X2 = 2'h0,
        MODE_32X1 = 2'h1,
        MODE_16X1 = 2'h2,
        MODE_DUAL = 2'h3
    } mem_mode_t;
    typedef enum logic [1:0] {
        SRC_F = 2'h0,
        SRC_G = 2'h1,
        SRC_H = 2'h2,
        SRC_DATA_IN = 2'h3
    } ff_src_t;
    typedef struct packed {
        logic ff_fall;
        ff_src_t yq_src;
        ff_src_t xq_src;
        logic y_sel_h;
        logic x_sel_h;
        logic wclk_fall;
        logic level_mode;
        mem_mode_t mode;
    } ctrl_t;
    typedef enum logic [2:0] {
        REG_CTRL = 3'h0,
        REG_HFUNC = 3'h1,
        REG_INIT_A = 3'h2,
        REG_INIT_B = 3'h3,
        REG_STATUS = 3'h4,
        REG_NONE = 3'h5
    } reg_sel_t;
endpackage

/* File: src/lut_distributed_ram.sv */
// Logic-block distributed memory with AXI4-Lite configuration and status
`timescale 1ns/1ps
`include "lut_ram_defs.svh"
module lut_distributed_ram #(
    parameter int unsigned STALL_CYCLES = `STALL_CYCLES
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic awvalid,
    output logic awready,
    input wire logic [`ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [`ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Fabric side pins
    input wire logic block_clock,
    input wire logic [3:0] table_a_address,
    input wire logic [3:0] table_b_address,
    input wire logic direct_in_line,
    input wire logic third_gen_input_one,
    input wire logic set_reset_line,
    // Fabric side results
    output logic x_out,
    output logic y_out,
    output logic single_port_output,
    output logic second_port_output,
    output logic xq_out,
    output logic yq_out
);
    // Register decode, shared by the read and write paths
    function automatic lut_ram_pkg::reg_sel_t decode(input logic [`ADDR_W-1:0] addr);
        case (addr)
            `OFF_CTRL: decode = lut_ram_pkg::REG_CTRL;
            `OFF_HFUNC: decode = lut_ram_pkg::REG_HFUNC;
            `OFF_INIT_A: decode = lut_ram_pkg::REG_INIT_A;
            `OFF_INIT_B: decode = lut_ram_pkg::REG_INIT_B;
            `OFF_STATUS: decode = lut_ram_pkg::REG_STATUS;
            default: decode = lut_ram_pkg::REG_NONE;
        endcase
    endfunction

    // Byte-lane merge for narrow registers
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                merge[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    // Configuration, status and bus state
    lut_ram_pkg::ctrl_t ctrl_reg;
    logic [7:0] hfunc_reg;
    logic stall_reg;
    logic [`CNT_W-1:0] stall_cnt_reg;
    logic clk_prev_reg;
    logic xq_reg;
    logic yq_reg;
    logic aw_hold_reg;
    logic w_hold_reg;
    logic [`ADDR_W-1:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // Two tables of sixteen cells; no reset, zero after configuration
    logic [15:0] lut_mem [0:1] = '{`MEM_INIT, `MEM_INIT};

    // Bus handshakes; one write and one read under way at most
    assign awready = !aw_hold_reg && !bvalid_reg;
    assign wready = !w_hold_reg && !bvalid_reg;
    assign arready = !rvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    wire lut_ram_pkg::reg_sel_t wr_sel = decode(awaddr_reg);
    wire lut_ram_pkg::reg_sel_t rd_sel = decode(araddr);
    wire commit = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire cfg_load_a = commit && (wr_sel == lut_ram_pkg::REG_INIT_A);
    wire cfg_load_b = commit && (wr_sel == lut_ram_pkg::REG_INIT_B);
    wire stall_clear = commit && (wr_sel == lut_ram_pkg::REG_STATUS) && wstrb_reg[0]
        && wdata_reg[`STS_STALL_BIT];
    wire [31:0] wr_merged_ctrl = merge({21'h000000, ctrl_reg}, wdata_reg, wstrb_reg);
    wire [31:0] wr_merged_h = merge({24'h000000, hfunc_reg}, wdata_reg, wstrb_reg);
    wire [31:0] wr_merged_a = merge({16'h0000, lut_mem[0]}, wdata_reg, wstrb_reg);
    wire [31:0] wr_merged_b = merge({16'h0000, lut_mem[1]}, wdata_reg, wstrb_reg);

    // Control-line redefinition in memory mode
    wire mem_data_in_first = direct_in_line;
    wire mem_data_in_second = third_gen_input_one;
    wire we = set_reset_line;
    wire [3:0] second_read_address = table_b_address;

    wire lut_ram_pkg::mem_mode_t mode = ctrl_reg.mode;
    wire is_dual = (mode == lut_ram_pkg::MODE_DUAL);
    wire is_32 = (mode == lut_ram_pkg::MODE_32X1);
    wire is_16x2 = (mode == lut_ram_pkg::MODE_16X2);
    // Dual-port always writes on the clock edge
    wire level_timing = ctrl_reg.level_mode && !is_dual;

    // Block clock edges, taken from the sampled pin level
    wire clk_rise = block_clock && !clk_prev_reg;
    wire clk_fall = !block_clock && clk_prev_reg;
    wire wr_edge = ctrl_reg.wclk_fall ? clk_fall : clk_rise;
    wire ff_edge = ctrl_reg.ff_fall ? clk_fall : clk_rise;
    // Level mode: enable is the strobe; edge mode: enable only qualifies the edge
    wire strobe = level_timing ? we : (wr_edge && we);

    // Per-table write enable, address and data
    logic [1:0] wr_en;
    logic [1:0][3:0] wr_addr;
    logic [1:0] wr_data;
    genvar t;
    generate
        for (t = 0; t < 2; t++) begin : g_tab
            wire own_addr = (t == 1) && is_16x2;
            wire sel = is_32 ? (mem_data_in_second == 1'(t))
                : (mode == lut_ram_pkg::MODE_16X1) ? (t == 0) : 1'b1;
            assign wr_en[t] = strobe && sel;
            assign wr_addr[t] = own_addr ? table_b_address : table_a_address;
            assign wr_data[t] = own_addr ? mem_data_in_second : mem_data_in_first;
        end
    endgenerate

    // Reads: plain lookup; the second table's read address is chosen by the mode
    wire [3:0] rd_addr_b = is_dual ? second_read_address : is_32 ? table_a_address : table_b_address;
    wire f_val = lut_mem[0][table_a_address];
    wire g_val = lut_mem[1][rd_addr_b];
    // Third generator as function of both table outputs and the second data input; in 32x1 it picks the half
    wire h_val = is_32 ? (mem_data_in_second ? g_val : f_val)
        : hfunc_reg[{mem_data_in_second, g_val, f_val}];
    assign single_port_output = is_32 ? h_val : f_val;
    assign second_port_output = g_val;
    assign x_out = (ctrl_reg.x_sel_h || is_32) ? h_val : f_val;
    assign y_out = ctrl_reg.y_sel_h ? h_val : g_val;
    assign xq_out = xq_reg;
    assign yq_out = yq_reg;

    // Flop source selection, also used for the second flop
    function automatic logic pick(input lut_ram_pkg::ff_src_t s, input logic f, input logic g,
        input logic h, input logic d);
        case (s)
            lut_ram_pkg::SRC_F: pick = f;
            lut_ram_pkg::SRC_G: pick = g;
            lut_ram_pkg::SRC_H: pick = h;
            default: pick = d;
        endcase
    endfunction

    // Contents: configuration load wins, then the internal write pulse
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 2; i++) begin
            if (wr_en[i]) begin
                lut_mem[i][wr_addr[i]] <= wr_data[i];
            end
        end
        if (cfg_load_a) begin
            lut_mem[0] <= wr_merged_a[15:0];
        end
        if (cfg_load_b) begin
            lut_mem[1] <= wr_merged_b[15:0];
        end
    end

    // Block flops capture on their own edge, cleared by reset unlike the tables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xq_reg <= 1'b0;
            yq_reg <= 1'b0;
            clk_prev_reg <= block_clock; // Tracks the pin so release shows no false edge
        end else begin
            clk_prev_reg <= block_clock;
            if (ff_edge) begin
                xq_reg <= pick(ctrl_reg.xq_src, f_val, g_val, h_val, mem_data_in_first);
                yq_reg <= pick(ctrl_reg.yq_src, f_val, g_val, h_val, mem_data_in_first);
            end
        end
    end

    // Watch the phase after the active edge; a stopped clock there is a hazard
    wire post_edge_level = ctrl_reg.wclk_fall ? !block_clock : block_clock;
    wire stall_hit = (stall_cnt_reg >= STALL_CYCLES[`CNT_W-1:0]);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stall_cnt_reg <= '0;
        end else if (!post_edge_level || level_timing) begin
            stall_cnt_reg <= '0;
        end else if (!stall_hit) begin
            stall_cnt_reg <= stall_cnt_reg + 1'b1;
        end
    end

    // Sticky flag: a new hit wins over a clear in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stall_reg <= 1'b0;
        end else begin
            stall_reg <= stall_hit || (stall_reg && !stall_clear);
        end
    end

    // Write channel: address and data in any order, response after both
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg <= awaddr;
            end
            if (wvalid && wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (commit) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (wr_sel == lut_ram_pkg::REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
            end else if (bvalid_reg && bready) begin
                bvalid_reg <= 1'b0;
            end
        end
    end

    // Control registers, written on commit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= `CTRL_RESET;
            hfunc_reg <= `HFUNC_RESET;
        end else if (commit && wr_sel == lut_ram_pkg::REG_CTRL) begin
            ctrl_reg <= wr_merged_ctrl[`CTRL_W-1:0];
        end else if (commit && wr_sel == lut_ram_pkg::REG_HFUNC) begin
            hfunc_reg <= wr_merged_h[7:0];
        end
    end

    // Read data selection
    logic [31:0] rd_word;
    always_comb begin
        case (rd_sel)
            lut_ram_pkg::REG_CTRL: rd_word = {21'h000000, ctrl_reg};
            lut_ram_pkg::REG_HFUNC: rd_word = {24'h000000, hfunc_reg};
            lut_ram_pkg::REG_INIT_A: rd_word = {16'h0000, lut_mem[0]};
            lut_ram_pkg::REG_INIT_B: rd_word = {16'h0000, lut_mem[1]};
            lut_ram_pkg::REG_STATUS: rd_word = {27'h0000000, stall_reg, yq_reg, xq_reg, y_out, x_out};
            default: rd_word = 32'h00000000;
        endcase
    end

    // Read channel: answer on the same edge that takes the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= (rd_sel == lut_ram_pkg::REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (rvalid_reg && rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // Checks on the write and read paths and on the stall flag
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_write_taken;
        wr_en[0] && !cfg_load_a;
    endsequence
    sequence s_cell_holds;
        lut_mem[0][$past(wr_addr[0])] == $past(wr_data[0]);
    endsequence

    property p_edge_only;
        (!level_timing && !wr_edge) |-> (wr_en == 2'b00);
    endproperty
    a_edge_only: assert property (p_edge_only) else $error("write without active edge");

    property p_level_strobe;
        (level_timing && is_16x2 && we) |-> (wr_en == 2'b11);
    endproperty
    a_level_strobe: assert property (p_level_strobe) else $error("level write missed");

    property p_cell_update;
        s_write_taken |=> s_cell_holds;
    endproperty
    a_cell_update: assert property (p_cell_update) else $error("cell not updated");

    property p_read_after_write;
        (s_write_taken and (!is_32 && wr_addr[0] == table_a_address)) ##1 ($stable(table_a_address) && !cfg_load_a)
            |-> single_port_output == $past(wr_data[0]);
    endproperty
    a_read_after_write: assert property (p_read_after_write) else $error("stale read after write");

    property p_dual_write;
        (is_dual && strobe) |-> (wr_en == 2'b11 && wr_addr[1] == table_a_address && wr_data[1] == mem_data_in_first);
    endproperty
    a_dual_write: assert property (p_dual_write) else $error("dual write port wrong");

    property p_wide_select;
        (is_32 && strobe) |-> (wr_en == {mem_data_in_second, !mem_data_in_second});
    endproperty
    a_wide_select: assert property (p_wide_select) else $error("32x1 half select wrong");

    property p_no_enable;
        !we |-> (wr_en == 2'b00);
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("write with enable low");

    property p_wrong_edge;
        (!level_timing && ctrl_reg.wclk_fall && clk_rise) |-> (wr_en == 2'b00);
    endproperty
    a_wrong_edge: assert property (p_wrong_edge) else $error("write on inactive edge");

    property p_stall_flag;
        (stall_cnt_reg == STALL_CYCLES[`CNT_W-1:0]) |=> stall_reg;
    endproperty
    a_stall_flag: assert property (p_stall_flag) else $error("stall flag not set");
endmodule

/* File: test/fabric_logic.sv */
// Model of the user fabric logic that drives the memory pins
`timescale 1ns/1ps
module fabric_logic (
    // Clock
    input wire logic aclk,
    // Memory pins
    output logic block_clock,
    output logic [3:0] table_a_address,
    output logic [3:0] table_b_address,
    output logic direct_in_line,
    output logic third_gen_input_one,
    output logic set_reset_line
);
    // Pins start idle with no write strobe
    initial begin
        block_clock = 1'b0;
        table_a_address = 4'h0;
        table_b_address = 4'h0;
        direct_in_line = 1'b0;
        third_gen_input_one = 1'b0;
        set_reset_line = 1'b0;
    end

    // Read addresses and the fifth address bit
    task automatic set_addr(input logic [3:0] a, input logic [3:0] b, input logic x1);
        @(posedge aclk);
        table_a_address <= a;
        table_b_address <= b;
        third_gen_input_one <= x1;
    endtask

    // Park the clock away from the post-edge phase
    task automatic set_idle(input logic fall);
        @(posedge aclk);
        block_clock <= fall;
    endtask

    // One write; data flips as enable drops, one cycle after the active edge
    task automatic write(input logic lvl, input logic fall, input logic [3:0] a, input logic [3:0] b,
        input logic x0, input logic x1, input logic en);
        set_addr(a, b, x1);
        direct_in_line <= x0;
        set_reset_line <= en & ~lvl;
        @(posedge aclk);
        if (lvl) begin
            set_reset_line <= en;
        end else begin
            block_clock <= ~fall;
        end
        @(posedge aclk);
        // Post-edge phase kept to one cycle, never stopped there
        block_clock <= fall;
        direct_in_line <= ~x0;
        set_reset_line <= 1'b0;
    endtask
endmodule

/* File: test/lut_distributed_ram_bench.sv */
// Self-checking bench of the distributed memory against a reference model
`timescale 1ns/1ps
module lut_distributed_ram_bench;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic block_clock, direct_in_line, third_gen_input_one, set_reset_line;
    logic x_out, y_out, single_port_output, second_port_output, xq_out, yq_out;
    logic [3:0] table_a_address, table_b_address;
    int err_total, checked, md, hf;
    int ma[16];
    int mb[16];
    // Control words: [1:0] mode, [2] level timing, [3] falling write edge
    logic [3:0] cfgs [9] = '{4'h0, 4'h8, 4'h1, 4'h9, 4'h2, 4'h3, 4'hB, 4'h4, 4'h6};

    lut_distributed_ram #(.STALL_CYCLES(20)) DUT (
        .aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid, .wready, .wdata,
        .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .arprot(3'h0),
        .rvalid, .rready, .rdata, .rresp, .block_clock, .table_a_address, .table_b_address,
        .direct_in_line, .third_gen_input_one, .set_reset_line, .x_out, .y_out,
        .single_port_output, .second_port_output, .xq_out, .yq_out
    );
    fabric_logic u_fab (.aclk, .block_clock, .table_a_address, .table_b_address,
        .direct_in_line, .third_gen_input_one, .set_reset_line);

    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk_bit(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %0b seen %0b", n, e, g);
        end
    endtask

    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask

    // Ready sampled mid-cycle, so it is the value seen at the next edge
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic pa, pw, ta, tw;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (pa || pw) begin
            @(negedge aclk);
            ta = pa && awready;
            tw = pw && wready;
            @(posedge aclk);
            pa = pa && !ta;
            pw = pw && !tw;
            awvalid <= pa;
            wvalid <= pw;
        end
        bready <= 1'b1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do @(negedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask

    // Model write: 16x2 two arrays, 32x1 half chosen by the fifth bit, dual writes both
    task automatic model_write(input logic [3:0] a, input logic [3:0] b, input logic x0, input logic x1);
        if (md == 1 && x1) begin
            mb[a] = x0;
        end else begin
            ma[a] = x0;
        end
        if (md == 0) begin
            mb[b] = x1;
        end
        if (md == 3) begin
            mb[a] = x0;
        end
    endtask

    // Combinational read of both ports, no clock edge needed
    // In 32x1 both tables share the first address; third generator used only when hf is set
    task automatic look(input logic [3:0] a, input logic [3:0] b, input logic x1);
        logic e1, e2;
        u_fab.set_addr(a, b, x1);
        #1;
        e1 = 1'((md == 1 && x1) ? mb[a] : ma[a]);
        e2 = 1'(mb[(md == 1) ? a : b]);
        chk_bit("first port", e1, single_port_output);
        chk_bit("second port", e2, second_port_output);
        chk_bit("x out", e1, x_out);
        chk_bit("y out", (hf < 0) ? e2 : 1'(hf >> {x1, e2, e1}), y_out);
    endtask

    task automatic sweep();
        for (int i = 0; i < 16; i++) begin
            look(4'(i), 4'(i), 1'b0);
        end
    endtask

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Hang guard, well beyond the expected run
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        stop_test();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [3:0] c, a, b;
        logic x0, x1, en;
        void'($urandom(85396));
        aresetn = 1'b0;
        awvalid = 1'b0;
        wvalid = 1'b0;
        bready = 1'b0;
        arvalid = 1'b0;
        rready = 1'b0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        err_total = 0;
        checked = 0;
        md = 0;
        hf = -1;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        // Power-up contents and reset control value
        sweep();
        axi_read(8'h00, d, r);
        chk_word("control reset", 32'h0, d);
        // Unmapped place refuses
        axi_write(8'h20, $urandom, r);
        chk_word("unmapped write resp", 32'h2, {30'h0, r});
        axi_read(8'h20, d, r);
        chk_word("unmapped read resp", 32'h2, {30'h0, r});
        chk_word("unmapped read data", 32'h0, d);
        // Every organisation and timing, random traffic with some enables low
        foreach (cfgs[k]) begin
            c = cfgs[k];
            md = c[1:0];
            u_fab.set_idle(c[3] & ~c[2]);
            axi_write(8'h00, {28'h0, c}, r);
            axi_read(8'h00, d, r);
            chk_word("control", {28'h0, c}, d);
            for (int i = 0; i < 16; i++) begin
                a = 4'($urandom);
                b = (md == 1) ? a : 4'($urandom);
                x0 = 1'($urandom);
                x1 = 1'($urandom);
                en = ($urandom % 4) != 0;
                u_fab.write(c[2], c[3], a, b, x0, x1, en);
                if (en) begin
                    model_write(a, b, x0, x1);
                end
                look(a, b, x1);
                look(4'($urandom), 4'($urandom), 1'b0);
            end
        end
        axi_read(8'h10, d, r);
        chk_bit("stall flag", 1'b0, d[4]);
        // Flops, third generator: xq from G', yq from data input, y from H'
        hf = $urandom % 256;
        axi_write(8'h04, 32'(hf), r);
        axi_write(8'h00, 32'h00000360, r);
        md = 0;
        a = 4'($urandom);
        b = 4'($urandom);
        x0 = 1'($urandom);
        u_fab.write(1'b0, 1'b0, a, b, x0, 1'b0, 1'b0);
        look(a, b, 1'b1);
        chk_bit("xq", 1'(mb[b]), xq_out);
        chk_bit("yq", x0, yq_out);
        // Clock parked in the post-edge phase on purpose, then released and cleared
        u_fab.set_idle(1'b1);
        repeat (30) @(posedge aclk);
        axi_read(8'h10, d, r);
        chk_bit("stall set", 1'b1, d[4]);
        u_fab.set_idle(1'b0);
        axi_write(8'h10, 32'h00000010, r);
        axi_read(8'h10, d, r);
        chk_bit("stall cleared", 1'b0, d[4]);
        // Second reset leaves contents alone
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        md = 0;
        hf = -1;
        sweep();
        stop_test();
    end
endmodule
